// ---- include/gmii_status_pkg.sv ----
package gmii_status_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ctrl_off      = 12'h000;
	localparam logic [11:0] pcs_in_off    = 12'h004;
	localparam logic [11:0] status_off    = 12'h008;
	localparam logic [11:0] lp_abil_off   = 12'h00c;
	localparam logic [11:0] mgmt_stat_off = 12'h010;
	localparam logic [31:0] ctrl_reset    = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int an_enable_bit  = 0;
	localparam int sgmii_mode_bit = 1;
	localparam int phy_side_bit   = 2;

	// ----------------------------------------------------------------
	// Status vector and management link bit positions
	// ----------------------------------------------------------------
	localparam int sv_link        = 0;
	localparam int sv_sync        = 1;
	localparam int sv_config      = 2;
	localparam int sv_idle        = 3;
	localparam int sv_invalid     = 4;
	localparam int sv_disp        = 5;
	localparam int sv_notab       = 6;
	localparam int sv_phy_link    = 7;
	localparam int sv_fault_lo    = 8;
	localparam int sv_speed_lo    = 10;
	localparam int sv_duplex      = 12;
	localparam int sv_rfault      = 13;
	localparam int sv_pause_lo    = 14;
	localparam int mgmt_link_bit  = 2;

	// ----------------------------------------------------------------
	// Receive code values
	// ----------------------------------------------------------------
	localparam logic [7:0] carrier_ext_code = 8'h0f;
	localparam logic [7:0] late_error_code  = 8'h1f;
	localparam logic [7:0] false_carr_code  = 8'h0e;

	// Byte-wide GMII bundle
	typedef struct packed {
		logic       en;
		logic       er;
		logic [7:0] d;
	} gmii_byte_t;

	// Decoder side per-cycle flags
	typedef struct packed {
		logic config_set_seen;
		logic idle_set_seen;
		logic ordered_set_invalid;
		logic disparity_error_flag;
		logic unknown_code_group_flag;
	} code_flags_t;
endpackage : gmii_status_pkg

// ---- rtl/pcs_gmii_client_status.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Transmit bytes pass opaque while enable high.
// - Error marks carried through both paths.
// - Carrier extension is error with 0x0F.
// - Receive error inside valid marks bad frame.
// - Late error in extension shows 0x1F.
// - False carrier on bad start or noise.
// - All client signals on one 125 MHz clock.
// - Bit 0 is sync and, when negotiation is enabled, negotiation done.
// - Link status mirrored in management bit 1.2.
// - Bit 1 follows synchronisation state directly.
// - Bit 7 remote PHY link, SGMII only.
// - Bits 6:2 aligned with receive bytes.
// - Bit 2 config sets, bit 3 idles.
// - Bit 4 flags invalid ordered set data.
// - Bits 5,6 disparity and unknown code group.
// - Bits 9:8 remote fault, zero on SGMII PHY side.
// - Bits 11:10 negotiated speed encoding.
// - Bit 12 negotiated duplex.
// - Bit 13 sticky fault, cleared on management status read.
// - Bits 15:14 mirror partner ability 8:7.
module pcs_gmii_client_status (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       clk_en,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Client transmit side
	input  wire gmii_status_pkg::gmii_byte_t tx_in,
	output gmii_status_pkg::gmii_byte_t      tx_out,
	// PCS receive side
	input  wire gmii_status_pkg::gmii_byte_t rx_in,
	input  wire logic                       rx_false_carrier,
	input  wire logic                       rx_extend,
	input  wire logic                       rx_late_error,
	input  wire gmii_status_pkg::code_flags_t rx_flags,
	// PCS state
	input  wire logic                       sync_ok,
	input  wire logic                       an_complete,
	input  wire logic                       phy_link_up,
	input  wire logic                       remote_fault_event,
	// Client receive side
	output gmii_status_pkg::gmii_byte_t      rx_out,
	output logic      [15:0]                status_vector
);
	import gmii_status_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [15:0] lp_abil_r;
	logic [1:0]  fault_enc_r;
	logic [1:0]  speed_r;
	logic        duplex_r;
	logic        rfault_r;
	logic        sync_q1_r;
	logic        sync_r;
	logic        an_q1_r;
	logic        an_r;
	logic        phy_q1_r;
	logic        phy_r;

	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        an_en;
	logic        sgmii;
	logic        phy_side;
	logic        link_ok;
	logic        mgmt_rd;

	assign an_en    = ctrl_r[an_enable_bit];
	assign sgmii    = ctrl_r[sgmii_mode_bit];
	assign phy_side = ctrl_r[phy_side_bit];
	assign addr_ok  = (paddr == ctrl_off) || (paddr == pcs_in_off) || (paddr == status_off)
		|| (paddr == lp_abil_off) || (paddr == mgmt_stat_off);
	assign wr_en    = clk_en && psel && penable && pwrite && pready && addr_ok;
	assign rd_en    = clk_en && psel && penable && !pwrite && pready;
	assign mgmt_rd  = rd_en && (paddr == mgmt_stat_off);

	// ----------------------------------------------------------------
	// Synchronisers for PCS level states
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q1_r <= 1'b0;
			sync_r    <= 1'b0;
			an_q1_r   <= 1'b0;
			an_r      <= 1'b0;
			phy_q1_r  <= 1'b0;
			phy_r     <= 1'b0;
		end else if (clk_en) begin
			sync_q1_r <= sync_ok;
			sync_r    <= sync_q1_r;
			an_q1_r   <= an_complete;
			an_r      <= an_q1_r;
			phy_q1_r  <= phy_link_up;
			phy_r     <= phy_q1_r;
		end
	end

	// Link is sync qualified by negotiation when enabled
	assign link_ok = sync_r && (!an_en || an_r);

	// ----------------------------------------------------------------
	// Software written registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r      <= ctrl_reset;
			lp_abil_r   <= 16'h0000;
			fault_enc_r <= 2'h0;
			speed_r     <= 2'h0;
			duplex_r    <= 1'b0;
		end else if (wr_en) begin
			if (paddr == ctrl_off) begin
				ctrl_r <= {29'h0, pwdata[2:0]};
			end
			if (paddr == pcs_in_off) begin
				fault_enc_r <= pwdata[1:0];
				speed_r     <= pwdata[3:2];
				duplex_r    <= pwdata[4];
			end
			if (paddr == lp_abil_off) begin
				lp_abil_r <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sticky remote fault, set wins over read clear
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rfault_r <= 1'b0;
		end else if (clk_en) begin
			if (remote_fault_event) begin
				rfault_r <= 1'b1;
			end else if (mgmt_rd) begin
				rfault_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave: zero wait states, error on unmapped address
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (1'b1)
					paddr == ctrl_off:      prdata <= ctrl_r;
					paddr == pcs_in_off:    prdata <= {27'h0, duplex_r, speed_r, fault_enc_r};
					paddr == status_off:    prdata <= {16'h0, status_vector};
					paddr == lp_abil_off:   prdata <= {16'h0, lp_abil_r};
					paddr == mgmt_stat_off: prdata <= {29'h0, link_ok, 2'h0};
					default:                prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit path: opaque one cycle pipe
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_out <= '0;
		end else if (clk_en) begin
			tx_out.en <= tx_in.en;
			tx_out.d  <= tx_in.d;
			tx_out.er <= tx_in.er;
		end
	end

	// ----------------------------------------------------------------
	// Receive path with special code insertion
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_out <= '0;
		end else if (clk_en) begin
			if (rx_false_carrier && !rx_in.en) begin
				rx_out <= '{en: 1'b0, er: 1'b1, d: false_carr_code};
			end else if (rx_extend && !rx_in.en) begin
				// Late error wins over plain extension
				rx_out <= '{en: 1'b0, er: 1'b1,
					d: rx_late_error ? late_error_code : carrier_ext_code};
			end else begin
				rx_out.en <= rx_in.en;
				rx_out.d  <= rx_in.d;
				rx_out.er <= rx_in.er && rx_in.en;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status vector, code flags share the receive pipe stage
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_vector <= 16'h0000;
		end else if (clk_en) begin
			status_vector[sv_link]     <= link_ok;
			status_vector[sv_sync]     <= sync_r;
			status_vector[sv_config]   <= rx_flags.config_set_seen;
			status_vector[sv_idle]     <= rx_flags.idle_set_seen;
			status_vector[sv_invalid]  <= rx_flags.ordered_set_invalid;
			status_vector[sv_disp]     <= rx_flags.disparity_error_flag;
			status_vector[sv_notab]    <= rx_flags.unknown_code_group_flag;
			status_vector[sv_phy_link] <= sgmii && an_r && phy_r;
			status_vector[sv_fault_lo+:2] <= (sgmii && phy_side) ? 2'h0 : fault_enc_r;
			status_vector[sv_speed_lo+:2] <= speed_r;
			status_vector[sv_duplex]   <= duplex_r;
			status_vector[sv_rfault]   <= rfault_r;
			status_vector[sv_pause_lo+:2] <= lp_abil_r[8:7];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	tx_data_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en |-> tx_out.d == $past(tx_in.d) && tx_out.en == $past(tx_in.en))
		else $error("transmit byte not passed");
	tx_err_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en |-> tx_out.er == $past(tx_in.er))
		else $error("transmit error lost");
	false_carr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && rx_false_carrier && !rx_in.en) ##1 clk_en |->
		!rx_out.en && rx_out.er && rx_out.d == false_carr_code)
		else $error("false carrier code wrong");
	extend_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && rx_extend && !rx_late_error && !rx_false_carrier && !rx_in.en) ##1 clk_en
		|-> rx_out.er && rx_out.d == carrier_ext_code)
		else $error("carrier extension code wrong");
	late_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && rx_extend && rx_late_error && !rx_false_carrier && !rx_in.en) ##1 clk_en
		|-> rx_out.er && rx_out.d == late_error_code)
		else $error("late error code wrong");
	link_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
		status_vector[sv_link] |-> status_vector[sv_sync])
		else $error("link up without sync");
	flags_align_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[6:2] == $past({rx_flags.unknown_code_group_flag,
		rx_flags.disparity_error_flag, rx_flags.ordered_set_invalid, rx_flags.idle_set_seen,
		rx_flags.config_set_seen}) && (rx_out.d == $past(rx_in.d) || $past(rx_false_carrier || rx_extend)))
		else $error("code flags misaligned");
	phy_link_a: assert property (@(posedge pclk) disable iff (!presetn)
		!sgmii && $past(!sgmii) |-> !status_vector[sv_phy_link])
		else $error("phy link high outside sgmii");
	rfault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(rfault_r) && !$past(mgmt_rd) |-> rfault_r)
		else $error("remote fault cleared without read");
	pause_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en ##1 clk_en && $stable(lp_abil_r)
		|-> status_vector[15:14] == lp_abil_r[8:7])
		else $error("pause bits not mirrored");

	// ----------------------------------------------------------------
	// Receive path and status field checks
	// ----------------------------------------------------------------
	// Frame bytes and their error marks pass unchanged
	rx_err_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && rx_in.en) |=> rx_out.en && rx_out.er == $past(rx_in.er)
		&& rx_out.d == $past(rx_in.d))
		else $error("frame error mark lost");
	rx_idle_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !rx_in.en && !rx_extend && !rx_false_carrier) |=> !rx_out.en && !rx_out.er)
		else $error("error raised outside frame");
	// Management copy of the link bit
	mgmt_link_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && !pwrite && paddr == mgmt_stat_off)
		|=> prdata[mgmt_link_bit] == $past(link_ok))
		else $error("management link bit wrong");
	// Link and sync bits
	sync_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[sv_sync] == $past(sync_r))
		else $error("sync bit not following sync");
	link_an_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && an_en && !an_r) |=> !status_vector[sv_link])
		else $error("link up before negotiation");
	phy_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && sgmii && an_r && phy_r) |=> status_vector[sv_phy_link])
		else $error("phy link not reported");
	// Code group flags, one bit each
	config_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[sv_config] == $past(rx_flags.config_set_seen)
		&& status_vector[sv_idle] == $past(rx_flags.idle_set_seen))
		else $error("config or idle bit wrong");
	invalid_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[sv_invalid] == $past(rx_flags.ordered_set_invalid))
		else $error("invalid set bit wrong");
	code_err_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[sv_disp] == $past(rx_flags.disparity_error_flag)
		&& status_vector[sv_notab] == $past(rx_flags.unknown_code_group_flag))
		else $error("decode error bits wrong");
	// Negotiation result fields
	fault_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && sgmii && phy_side) |=> status_vector[sv_fault_lo+:2] == 2'h0)
		else $error("fault encoding not zero on phy side");
	speed_duplex_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> status_vector[sv_speed_lo+:2] == $past(speed_r)
		&& status_vector[sv_duplex] == $past(duplex_r))
		else $error("speed or duplex not mirrored");
	// Sticky remote fault set and read clear
	rfault_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && remote_fault_event) |=> rfault_r)
		else $error("remote fault not set");
	rfault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mgmt_rd && !remote_fault_event) |=> !rfault_r)
		else $error("remote fault not cleared by read");
	// Clock enable low holds both byte outputs, the status vector and the control register
	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(tx_out) && $stable(rx_out) && $stable(status_vector) && $stable(ctrl_r))
		else $error("state moved while clock disabled");

	frame_rx_c:   cover property (@(posedge pclk) rx_out.en ##1 !rx_out.en);
	extend_c:     cover property (@(posedge pclk) rx_out.er && rx_out.d == carrier_ext_code);
	false_c:      cover property (@(posedge pclk) rx_out.er && rx_out.d == false_carr_code);
	fault_clr_c:  cover property (@(posedge pclk) rfault_r ##1 !rfault_r);
	late_c:       cover property (@(posedge pclk) rx_out.er && rx_out.d == late_error_code);
endmodule : pcs_gmii_client_status

// ---- testbench/gmii_client_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Client MAC stand-in
// ----------------------------------------
module gmii_client_model (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   go,
	input  wire logic [7:0]             rnd,
	output gmii_status_pkg::gmii_byte_t tx
);
	import gmii_status_pkg::*;
	int pos;
	// Preamble, delimiter, random payload, then idle with the last byte inverted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 0;
			tx  <= '0;
		end else if (go || pos != 0) begin
			pos   <= (pos == 23) ? 0 : pos + 1;
			tx.en <= (pos < 23);
			tx.d  <= (pos == 23) ? ~tx.d : (pos < 7) ? 8'h55 : (pos == 7) ? 8'hd5 : rnd;
			tx.er <= (pos > 8) && (pos < 23) && (rnd[7:5] == 3'h7);
		end
	end
endmodule : gmii_client_model

// ---- testbench/pcs_gmii_client_status_tb_top.sv ----
`timescale 1ns/1ps
module pcs_gmii_client_status_tb_top;
	import gmii_status_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, run, chk_on, ce;
	logic        rx_fc, rx_ext, rx_late, sync_ok, an_complete, phy_link_up, rfe, fault_m;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, ctrl_m, pcs_m, lp_m;
	logic [15:0] sv;
	logic [7:0]  rnd;
	gmii_byte_t  tx_in, tx_out, rx_in, rx_out, exp_tx, exp_rx;
	code_flags_t rx_flags, exp_fl;
	int          failures, n_checks, cyc;

	pcs_gmii_client_status uut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_in(tx_in), .tx_out(tx_out), .rx_in(rx_in),
		.rx_false_carrier(rx_fc), .rx_extend(rx_ext), .rx_late_error(rx_late), .rx_flags(rx_flags),
		.sync_ok(sync_ok), .an_complete(an_complete), .phy_link_up(phy_link_up),
		.remote_fault_event(rfe), .rx_out(rx_out), .status_vector(sv));
	gmii_client_model client (.pclk(pclk), .presetn(presetn), .go(go), .rnd(rnd), .tx(tx_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Expected slow status bits, code-group bits masked out
	function automatic logic [15:0] slow_sv();
		logic lk;
		lk = sync_ok & (an_complete | ~ctrl_m[an_enable_bit]);
		return {lp_m[8:7], fault_m, pcs_m[4], pcs_m[3:2], (ctrl_m[1] & ctrl_m[2]) ? 2'b00 : pcs_m[1:0],
			ctrl_m[1] & an_complete & phy_link_up, 5'h0, sync_ok, lk};
	endfunction : slow_sv

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task results();
		if (failures == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// APB master: setup, access until pready, then release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task check_slow();
		logic [15:0] e;
		repeat (5) @(posedge pclk);
		e = slow_sv();
		chk("status_vector", {16'h0, sv & 16'hff83}, {16'h0, e});
		apb(1'b0, status_off, 32'h0);
		chk("status reg", rd & 32'h0000_ff83, {16'h0, e});
		apb(1'b0, mgmt_stat_off, 32'h0);
		chk("mgmt link", {31'h0, rd[mgmt_link_bit]}, {31'h0, e[0]});
		fault_m = 1'b0;
		repeat (2) @(posedge pclk);
		chk("fault cleared", {31'h0, sv[13]}, 32'h0);
	endtask : check_slow

	// ----------------------------------------
	// Clock, random traffic, models, timeout
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Random receive stream, frames may lack any preamble
	always @(posedge pclk) begin
		seed = xs(seed);
		rnd <= seed[31:24];
		if (run) begin
			rx_in    <= seed[9:0];
			rx_flags <= seed[14:10];
			rx_fc    <= seed[15];
			rx_ext   <= seed[16] & ~seed[9];
			rx_late  <= seed[17];
			go       <= seed[20] & seed[21];
		end
	end

	// Reference model of both byte paths, frozen with the clock enable
	always @(posedge pclk) begin
		if (ce) begin
			exp_tx <= tx_in;
			exp_fl <= rx_flags;
			if (!rx_in.en && rx_fc)
				exp_rx <= {1'b0, 1'b1, false_carr_code};
			else if (rx_ext && !rx_in.en)
				exp_rx <= {1'b0, 1'b1, rx_late ? late_error_code : carrier_ext_code};
			else
				exp_rx <= {rx_in.en, rx_in.er & rx_in.en, rx_in.d};
		end
	end

	// Compare byte paths every cycle where settled
	always @(negedge pclk) begin
		if (chk_on) begin
			chk("tx_out", {22'h0, tx_out}, {22'h0, exp_tx});
			chk("rx_out", {22'h0, rx_out}, {22'h0, exp_rx});
			chk("code flags", {27'h0, sv[6:2]}, {27'h0, exp_fl.unknown_code_group_flag, exp_fl.disparity_error_flag,
				exp_fl.ordered_set_invalid, exp_fl.idle_set_seen, exp_fl.config_set_seen});
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		rx_in = '0; rx_flags = '0; rx_fc = 1'b0; rx_ext = 1'b0; rx_late = 1'b0; rnd = '0;
		sync_ok = 1'b0; an_complete = 1'b0; phy_link_up = 1'b0; rfe = 1'b0; go = 1'b0;
		run = 1'b0; chk_on = 1'b0; ce = 1'b1; seed = 32'hd8a9; ctrl_m = ctrl_reset; pcs_m = '0; lp_m = '0;
		fault_m = 1'b0; failures = 0; n_checks = 0; cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ctrl_off, 32'h0);
		chk("ctrl reset", rd, ctrl_reset);
		run <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_on <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			ctrl_m = i & 7;
			pcs_m = (i * 7) % 32;
			lp_m = i * 32'h61;
			apb(1'b1, ctrl_off, ctrl_m);
			apb(1'b1, pcs_in_off, pcs_m);
			apb(1'b1, lp_abil_off, lp_m);
			sync_ok <= i[3];
			an_complete <= i[4] ^ i[2];
			phy_link_up <= i[1] ^ i[3];
			if (i % 8 == 5) begin
				@(posedge pclk) rfe <= 1'b1;
				fault_m = 1'b1;
				@(posedge pclk) rfe <= 1'b0;
			end
			check_slow();
		end
		// Freeze all state, byte path compares keep running
		@(posedge pclk) ce <= 1'b0;
		repeat (12) @(posedge pclk);
		ce <= 1'b1;
		apb(1'b1, 12'h7f0, 32'hffff_ffff);
		chk("unmapped wr err", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h7f0, 32'h0);
		chk("unmapped rd err", {31'h0, err}, 32'h1);
		chk("unmapped rd data", rd, 32'h0);
		results();
	end
endmodule : pcs_gmii_client_status_tb_top
